// file: src/qhb_pkg.sv
/*
 * qhb_pkg: constants for the quad uart host bus select front end.
 * assumes: one synchronous clock domain; all pins sampled synchronously.
 */
// Function
// [R01] high style select means separate strobes, low means direction line.
// [R02] the style select has a weak pull-up so an open pin reads high; the code models no pull-up or port default.
// [R03] in direction-line style the write strobe pin is a read/write input.
// [R04] in direction-line style the reset pin is active low, not active high.
// [R05] in direction-line style the read strobe is ignored.
// [R06] direction-line style ORs the four interrupts onto one open-source pin.
// [R07] three low address bits pick a register in the channel, in both styles.
// [R08] dir style: two upper bits pick the channel while common select is low.
// [R09] in direction-line style a low common select enables all four channels.
// [R10] in separate-strobe style each channel has its own active-low select.
// [R11] separate-strobe style: a falling read strobe drives the register out.
// [R12] separate-strobe style: a falling write strobe stores the data bus.
// [R13] dir style: the upper bits are a binary channel index, zero to three.
package qhb_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int QHB_CHANNELS   = 4;
    localparam int QHB_REG_ABITS  = 3;
    localparam int QHB_DATA_BITS  = 8;

    // ************************************************************
    // encodings and reset values
    // ************************************************************
    localparam logic QHB_STYLE_STROBE = 1'b1;
    localparam logic QHB_STYLE_DIRLN  = 1'b0;
    localparam logic QHB_RW_READ      = 1'b1;
    localparam logic [7:0] QHB_REG_RST = 8'h00;

    typedef enum logic [1:0] {
        QHB_IDLE,
        QHB_RD,
        QHB_WR
    } qhb_cyc_t;

endpackage

// file: src/qhb_reg_mem.sv
/*
 * qhb_reg_mem: per-channel register store, 4 channels x 8 words.
 * assumes: caller gives one-cycle write pulses; read data registered.
 */
`timescale 1ns/100ps
module qhb_reg_mem
    import qhb_pkg::*;
#(
    parameter int CH = QHB_CHANNELS,
    parameter int AW = QHB_REG_ABITS,
    parameter int DW = QHB_DATA_BITS
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // access
    input  wire logic [1:0]    ch,
    input  wire logic [AW-1:0] addr,
    input  wire logic          we,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem_q [CH*(2**AW)];
    logic [DW-1:0] rdata_q;
    logic [DW-1:0] rdata_d;
    logic [$clog2(CH)+AW-1:0] idx;

    // the channel port is two bits wide, so at most four channels
    if (CH < 2 || CH > 4) begin : g_bad_cfg
        $error("qhb_reg_mem: channel count must be 2 to 4");
    end

    // flat index: channel above register
    assign idx = {ch[$clog2(CH)-1:0], addr};

    // read data always from a register
    always_comb begin
        rdata_d = mem_q[idx];
    end

    // ************************************************************
    // storage
    // ************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_q <= QHB_REG_RST;
            for (int i = 0; i < CH*(2**AW); i++) begin
                mem_q[i] <= QHB_REG_RST;
            end
        end else begin
            rdata_q <= rdata_d;
            if (we) begin
                mem_q[idx] <= wdata;
            end
        end
    end

    assign rdata = rdata_q;

endmodule // qhb_reg_mem

// file: src/qhb_host_port.sv
/*
 * qhb_host_port: host bus front end of a four-channel uart.
 * assumes: all pins synchronous to clk; the style strap is sampled every
 * cycle; pin-level pull-up of the strap is not modelled, the port has no default.
 */
`timescale 1ns/100ps
module qhb_host_port
    import qhb_pkg::*;
#(
    parameter int CH = QHB_CHANNELS,
    parameter int AW = QHB_REG_ABITS,
    parameter int DW = QHB_DATA_BITS
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // style strap; no pull-up is modelled, so it must be driven
    input  wire logic          bus_style_sel,
    // host reset pin, polarity set by style
    input  wire logic          host_reset,
    // chip selects: pin0 common/ch0, pins 1..2 idx bits/ch1..ch2, pin3 ch3
    input  wire logic          cs0_n,
    input  wire logic [1:0]    channel_index_bits,
    input  wire logic          cs3_n,
    // register index and strobes
    input  wire logic [AW-1:0] register_index,
    input  wire logic          read_strobe_n,
    input  wire logic          write_strobe_n,
    // data bus split into three signals
    input  wire logic [DW-1:0] data_in,
    output logic      [DW-1:0] data_out,
    output logic               data_oe,
    // channel interrupts from the serial engines
    input  wire logic [CH-1:0] chan_irq,
    // separate-strobe style per-channel interrupts
    output logic      [CH-1:0] irq_chan,
    // direction-line style open-source request
    output logic               irq_out,
    output logic               irq_oe,
    // internal reset request toward the channels
    output logic               chan_reset
);

    // decode and index widths are written for this one shape only
    if (CH != 4 || AW != 3 || DW != 8) begin : g_bad_cfg
        $error("qhb_host_port: only 4 ch, 3 addr bits, 8 data bits");
    end

    // ************************************************************
    // style decode and select
    // ************************************************************
    logic       strobe_style;
    logic       ch_hit;
    logic [1:0] ch_sel;
    logic       rd_lvl;
    logic       wr_lvl;
    logic       hreset;

    assign strobe_style = (bus_style_sel == QHB_STYLE_STROBE); // [R01] [R02]

    // channel decode per style
    always_comb begin
        ch_hit = 1'b0;
        ch_sel = 2'd0;
        if (strobe_style) begin
            // one-hot selects, lowest wins if several low
            if (!cs0_n) begin // [R10]
                ch_hit = 1'b1;
                ch_sel = 2'd0;
            end else if (!channel_index_bits[0]) begin // [R10]
                ch_hit = 1'b1;
                ch_sel = 2'd1;
            end else if (!channel_index_bits[1]) begin // [R10]
                ch_hit = 1'b1;
                ch_sel = 2'd2;
            end else if (!cs3_n) begin // [R10]
                ch_hit = 1'b1;
                ch_sel = 2'd3;
            end
        end else begin
            ch_hit = !cs0_n; // [R09] [R08]
            ch_sel = channel_index_bits; // [R13] [R08]
        end
    end

    // strobe levels: direction line replaces write, read unused
    always_comb begin
        if (strobe_style) begin
            rd_lvl = ch_hit && !read_strobe_n; // [R11]
            wr_lvl = ch_hit && !write_strobe_n && read_strobe_n; // [R12]
            hreset = host_reset;
        end else begin
            rd_lvl = ch_hit && (write_strobe_n == QHB_RW_READ); // [R03] [R05]
            wr_lvl = ch_hit && (write_strobe_n != QHB_RW_READ); // [R03]
            hreset = !host_reset; // [R04]
        end
    end

    // ************************************************************
    // access sequencer
    // ************************************************************
    qhb_cyc_t      st_q;
    qhb_cyc_t      st_d;
    logic          we;
    logic [1:0]    ch_q;
    logic [1:0]    ch_d;
    logic [AW-1:0] ra_q;
    logic [AW-1:0] ra_d;
    logic          oe_q;
    logic          oe_d;
    logic [DW-1:0] mem_rdata;

    // one access per strobe edge; a held strobe does not repeat writes
    always_comb begin
        st_d = st_q;
        ch_d = ch_q;
        ra_d = ra_q;
        we   = 1'b0;
        oe_d = 1'b0;
        unique case (st_q)
            QHB_IDLE: begin
                ch_d = ch_sel;
                ra_d = register_index; // [R07]
                if (rd_lvl) begin
                    st_d = QHB_RD;
                end else if (wr_lvl) begin
                    st_d = QHB_WR;
                    we   = 1'b1; // [R12]
                end
            end
            QHB_RD: begin
                ch_d = ch_sel;
                ra_d = register_index; // [R07]
                oe_d = rd_lvl; // [R11]
                if (!rd_lvl) begin
                    st_d = QHB_IDLE;
                end
            end
            QHB_WR: begin
                if (!wr_lvl) begin
                    st_d = QHB_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_q <= QHB_IDLE;
            ch_q <= 2'd0;
            ra_q <= '0;
            oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            ch_q <= ch_d;
            ra_q <= ra_d;
            oe_q <= oe_d;
        end
    end

    // write uses live address so data lands in the same cycle
    qhb_reg_mem #(
        .CH (CH),
        .AW (AW),
        .DW (DW)
    ) u_mem (
        .clk   (clk),
        .rst_n (rst_n),
        .ch    (we ? ch_sel : ch_q),
        .addr  (we ? register_index : ra_q),
        .we    (we),
        .wdata (data_in),
        .rdata (mem_rdata)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    logic [CH-1:0] irqc_q;
    logic [CH-1:0] irqc_d;
    logic          irq_q;
    logic          irq_d;
    logic          rst_q;
    logic          rst_d;

    // interrupt routing: wired or only in direction-line style
    always_comb begin
        irqc_d = strobe_style ? chan_irq : '0;
        irq_d  = !strobe_style && (|chan_irq); // [R06]
        rst_d  = hreset; // [R04]
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqc_q <= '0;
            irq_q  <= 1'b0;
            rst_q  <= 1'b0;
        end else begin
            irqc_q <= irqc_d;
            irq_q  <= irq_d;
            rst_q  <= rst_d;
        end
    end

    assign data_out   = mem_rdata;
    assign data_oe    = oe_q;
    assign irq_chan   = irqc_q;
    assign irq_out    = irq_q;
    assign irq_oe     = irq_q; // open source: drive only when high
    assign chan_reset = rst_q;

endmodule // qhb_host_port

// file: sim/qhb_chk_sva.sv
/* qhb_chk_sva: port checker for qhb_host_port.
   assumes: bound onto every qhb_host_port instance, one clock domain. */
`timescale 1ns/100ps
module qhb_chk_sva (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    // style strap and host reset pin
    input wire logic       bus_style_sel,
    input wire logic       host_reset,
    // bus pins
    input wire logic       cs0_n,
    input wire logic       read_strobe_n,
    input wire logic       write_strobe_n,
    input wire logic       data_oe,
    // interrupts and channel reset
    input wire logic [3:0] chan_irq,
    input wire logic [3:0] irq_chan,
    input wire logic       irq_out,
    input wire logic       irq_oe,
    input wire logic       chan_reset
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // outputs trail their causes by one cycle
    irq_copy_a: assert property (
        $past(rst_n) && $past(bus_style_sel) |->
        irq_chan == $past(chan_irq)) else $error("irq_chan copy lost");
    irq_quiet_a: assert property (
        $past(rst_n) && !$past(bus_style_sel) |->
        irq_chan == 4'h0) else $error("irq_chan active in dir style");
    irq_or_a: assert property (
        $past(rst_n) |-> irq_out ==
        (!$past(bus_style_sel) && |$past(chan_irq))) else $error("irq or");
    // open source: drive only in dir style and only with a request
    irq_drive_a: assert property (
        irq_oe == irq_out && (!irq_oe ||
        (!$past(bus_style_sel) && |$past(chan_irq))))
        else $error("irq_oe drives without a dir-style request");
    rst_high_a: assert property (
        $past(rst_n) && $past(bus_style_sel) |->
        chan_reset == $past(host_reset)) else $error("reset polarity hi");
    rst_low_a: assert property (
        $past(rst_n) && !$past(bus_style_sel) |->
        chan_reset == !$past(host_reset)) else $error("reset polarity lo");
    // the bus is driven only as the answer to a held request
    rd_launch_a: assert property (
        $rose(data_oe) && $past(bus_style_sel)
        |-> !$past(read_strobe_n)) else $error("oe without read strobe");
    dir_sel_a: assert property (
        data_oe && !$past(bus_style_sel) |->
        !$past(cs0_n)) else $error("oe without common select");
    dir_rw_a: assert property (
        data_oe && !$past(bus_style_sel) |->
        $past(write_strobe_n)) else $error("oe on dir-style write");
endmodule // qhb_chk_sva

bind qhb_host_port qhb_chk_sva u_chk (
    .clk            (clk),
    .rst_n          (rst_n),
    .bus_style_sel  (bus_style_sel),
    .host_reset     (host_reset),
    .cs0_n          (cs0_n),
    .read_strobe_n  (read_strobe_n),
    .write_strobe_n (write_strobe_n),
    .data_oe        (data_oe),
    .chan_irq       (chan_irq),
    .irq_chan       (irq_chan),
    .irq_out        (irq_out),
    .irq_oe         (irq_oe),
    .chan_reset     (chan_reset)
);

// file: sim/qhb_host_model.sv
/* qhb_host_model: host cpu on the parallel port, one access at a time.
   assumes: each task is entered just after a rising clock edge. */
`timescale 1ns/100ps
module qhb_host_model (
    // clock and strap seen by the host
    input  wire logic       clk,
    input  wire logic       style,
    // bus pins
    output logic            cs0_n,
    output logic            cs3_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic      [1:0] idx,
    output logic      [2:0] ra,
    output logic      [7:0] din
);
    initial {cs0_n, idx, cs3_n, rd_n, wr_n, ra, din} = '1;
    // request held until its answer edge; caller samples, then releases
    task automatic acc(input logic [1:0] ch, input logic [2:0] a,
                       input logic w, input logic [7:0] d, input logic s);
        ra = a;
        din = d;
        if (style) begin
            {cs3_n, idx, cs0_n} = ~(4'h1 << ch) | {4{!s}};
            rd_n = w;
            wr_n = !w;
        end else begin
            cs0_n = !s;
            idx = ch;
            wr_n = !w;
            rd_n = 1'($urandom); // noise, must not matter
        end
        repeat (w ? 1 : 2) @(posedge clk);
        #1;
    endtask
    // idle gap; released bus shows inverted data, not the old value
    task automatic rel();
        {cs0_n, idx, cs3_n, rd_n, wr_n} = '1;
        din = ~din;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule // qhb_host_model

// file: sim/quad_uart_host_bus_select_tb.sv
/* quad_uart_host_bus_select_tb: host port against a register model.
   assumes: qhb_host_model drives the bus; checker bound separately. */
`timescale 1ns/100ps
module quad_uart_host_bus_select_tb;
    logic       clk = 0, rst_n = 0, hrst = 0;
    logic       style = 1; // strap left open reads high
    logic [3:0] irq = 0, ic;
    logic       cs0_n, cs3_n, rd_n, wr_n, oe, io, ioe, crst;
    logic [1:0] idx;
    logic [2:0] ra;
    logic [7:0] din, dout;
    int         fail_count = 0, total_checks = 0, cyc = 0;
    int         exp [4][8];
    always #20 clk = ~clk;
    qhb_host_model u_host (.clk, .style, .cs0_n, .cs3_n, .rd_n, .wr_n,
        .idx, .ra, .din);
    qhb_host_port dut (.clk, .rst_n, .bus_style_sel(style),
        .host_reset(hrst), .cs0_n, .channel_index_bits(idx), .cs3_n,
        .register_index(ra), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
        .data_in(din), .data_out(dout), .data_oe(oe), .chan_irq(irq),
        .irq_chan(ic), .irq_out(io), .irq_oe(ioe), .chan_reset(crst));
    task automatic chk(input string n, input logic [7:0] e, s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    // one access; model updated on selected writes only
    task automatic xfer(input logic [1:0] c, input logic [2:0] a,
                        input logic w, s);
        logic [7:0] d;
        d = 8'($urandom);
        u_host.acc(c, a, w, d, s);
        if (w && s) exp[c][a] = d;
        if (!w) chk("data_oe", {7'h0, s}, {7'h0, oe});
        if (!w && s) chk("data_out", 8'(exp[c][a]), dout);
        u_host.rel();
    endtask
    // pin-level interrupt and reset paths, one cycle late
    task automatic sig();
        irq = 4'($urandom);
        hrst = 1'($urandom);
        @(posedge clk);
        #1;
        chk("irq_chan", style ? 8'(irq) : 8'h00, 8'(ic));
        chk("irq_out", {7'h0, !style && |irq}, {7'h0, io});
        chk("irq_oe", {7'h0, !style && |irq}, {7'h0, ioe});
        chk("chan_reset", {7'h0, style ~^ hrst}, {7'h0, crst});
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            print_verdict();
        end
    end
    initial begin
        logic [6:0] r;
        void'($urandom(29));
        repeat (12) @(posedge clk);
        #1 rst_n = 1;
        for (int i = 0; i < 32; i++) begin
            xfer(i[4:3], i[2:0], 1, 1);
        end
        for (int i = 0; i < 32; i++) begin
            xfer(i[4:3], i[2:0], 0, 1);
        end
        $display("test strobe style done");
        style = 0;
        hrst = 1;
        for (int i = 0; i < 96; i++) begin
            r = 7'($urandom);
            xfer(r[1:0], r[4:2], r[5], r[6]);
        end
        $display("test direction style done");
        style = 1;
        hrst = 0;
        // unselected strobe-style writes must leave every register alone
        for (int i = 0; i < 16; i++) begin
            r = 7'($urandom);
            xfer(r[1:0], r[4:2], 1, 0);
        end
        for (int i = 0; i < 32; i++) begin
            xfer(i[4:3], i[2:0], 0, 1);
        end
        $display("test cross style done");
        // mid-run reset clears the store and the bus drive
        rst_n = 0;
        repeat (2) @(posedge clk);
        #1 rst_n = 1;
        foreach (exp[i, j]) exp[i][j] = 0;
        chk("data_out", 8'h00, dout);
        chk("data_oe", 8'h00, {7'h0, oe});
        for (int i = 0; i < 8; i++) begin
            r = 7'($urandom);
            xfer(r[1:0], r[4:2], 0, 1);
        end
        $display("test reset clear done");
        for (int i = 0; i < 16; i++) begin
            style = i[0];
            sig();
        end
        $display("test interrupt and reset done");
        print_verdict();
    end
endmodule // quad_uart_host_bus_select_tb
